// [gpb_gpio_bank_pair.sv]
// Sixteen-pin GPIO block: APB register slave and two eight-pin banks.
// Assumes pin inputs are synchronous to CLK and a pad ring that combines
// each OUT/OE pair with its IN into a bidirectional pad.
//
// Functional notes
// - Sixteen general purpose pins, each one software configured.
// - Two control registers, each governing exactly eight pins.
// - Each pin has function select, direction and data bits; second-bank pins also have a special function bit.
// - Special function bit exists only in the second bank.
// - Reading a data bit returns the live pin level, whatever the direction.
// - Writing a data bit sets the level driven while the pin is an output.
// - All three configuration bits zero makes a plain input.
// - Direction one, others zero makes a plain output driving its data bit.
//
// Added by the designer: register access over APB and the placing of the registers.

`timescale 1ns/10ps

module gpb_gpio_bank_pair
  import gpb_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // APB slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [GPB_ADDR_W-1:0] PADDR,
  input  wire logic [GPB_DATA_W-1:0] PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic      [GPB_DATA_W-1:0] PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // Bank a pins
  input  wire logic [GPB_PINS-1:0]   GPIO_A_IN,
  output logic      [GPB_PINS-1:0]   GPIO_A_OUT,
  output logic      [GPB_PINS-1:0]   GPIO_A_OE,
  // Bank c pins
  input  wire logic [GPB_PINS-1:0]   GPIO_C_IN,
  output logic      [GPB_PINS-1:0]   GPIO_C_OUT,
  output logic      [GPB_PINS-1:0]   GPIO_C_OE,
  // Alternate function sources, chosen by the function select bit
  input  wire logic [GPB_PINS-1:0]   ALT_A_OUT,
  input  wire logic [GPB_PINS-1:0]   ALT_A_OE,
  input  wire logic [GPB_PINS-1:0]   ALT_C_OUT,
  input  wire logic [GPB_PINS-1:0]   ALT_C_OE,
  // Special function source of bank c
  input  wire logic [GPB_PINS-1:0]   SPF_C_OUT,
  input  wire logic [GPB_PINS-1:0]   SPF_C_OE
);

  logic                  setup_phase;
  logic                  access_done;
  logic                  hit_a;
  logic                  hit_c;
  logic                  hit;
  logic [GPB_DATA_W-1:0] cfg_a;
  logic [GPB_DATA_W-1:0] cfg_c;
  logic [GPB_DATA_W-1:0] rd_word;
  logic [GPB_DATA_W-1:0] cur_word;
  logic [GPB_DATA_W-1:0] merged;
  logic                  wr_a;
  logic                  wr_c;
  logic [GPB_DATA_W-1:0] next_prdata;
  logic                  next_pready;
  logic                  next_pslverr;

  // Phase decode; PREADY is a flop so the access cycle always ends in one
  assign setup_phase = PSEL & ~PENABLE;
  assign access_done = PSEL & PENABLE & PREADY;

  // Address decode
  always_comb begin
    hit_a = 1'b0;
    hit_c = 1'b0;
    if (PADDR == GPB_OFF_BANK_A) begin
      hit_a = 1'b1;
    end else if (PADDR == GPB_OFF_BANK_C) begin
      hit_c = 1'b1;
    end
  end
  assign hit = hit_a | hit_c;

  // Read word: config fields from the bank, data lane from the pins
  always_comb begin
    rd_word  = GPB_RD_UNMAPPED;
    cur_word = GPB_RD_UNMAPPED;
    if (hit_a) begin
      cur_word = cfg_a;
      rd_word  = {cfg_a[GPB_DATA_W-1:GPB_PINS], GPIO_A_IN};
    end else if (hit_c) begin
      cur_word = cfg_c;
      rd_word  = {cfg_c[GPB_DATA_W-1:GPB_PINS], GPIO_C_IN};
    end
  end

  // Byte strobes pick lanes; unstrobed fields keep their stored value,
  // which spares software a read-modify-write for single fields
  for (genvar k = 0; k < 4; k++) begin : g_lane
    assign merged[8*k +: 8] = PSTRB[k] ? PWDATA[8*k +: 8] : cur_word[8*k +: 8];
  end

  // Writes land only at the edge that completes the access
  assign wr_a = access_done & PWRITE & hit_a;
  assign wr_c = access_done & PWRITE & hit_c;

  // Answer prepared in setup, presented throughout the access cycle
  always_comb begin
    next_pready  = setup_phase;
    next_pslverr = setup_phase & ~hit;
    next_prdata  = GPB_RD_UNMAPPED;
    if (setup_phase & ~PWRITE & hit) begin
      next_prdata = rd_word;
    end
  end

  // Slave response registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= GPB_RD_UNMAPPED;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // Bank a: eight pins, no special function source
  gpb_pin_bank #(
    .HAS_SPF (1'b0)
  ) u_bank_a (
    .clk      (CLK),
    .rst      (RST),
    .wr_en    (wr_a),
    .wr_word  (merged),
    .alt_out  (ALT_A_OUT),
    .alt_oe   (ALT_A_OE),
    .spf_out  (GPB_RST_SPF),
    .spf_oe   (GPB_RST_SPF),
    .cfg_word (cfg_a),
    .pin_out  (GPIO_A_OUT),
    .pin_oe   (GPIO_A_OE)
  );

  // Bank c: eight pins with the special function bit
  gpb_pin_bank #(
    .HAS_SPF (1'b1)
  ) u_bank_c (
    .clk      (CLK),
    .rst      (RST),
    .wr_en    (wr_c),
    .wr_word  (merged),
    .alt_out  (ALT_C_OUT),
    .alt_oe   (ALT_C_OE),
    .spf_out  (SPF_C_OUT),
    .spf_oe   (SPF_C_OE),
    .cfg_word (cfg_c),
    .pin_out  (GPIO_C_OUT),
    .pin_oe   (GPIO_C_OE)
  );

endmodule : gpb_gpio_bank_pair

// [gpb_pair_asserts.sv]
// Checker for the GPIO bank pair, bound to its top module.
// Assumes full-word writes for the pin checks; partial strobes are skipped.
`timescale 1ns/10ps
module gpb_pair_asserts
  import gpb_pkg::*;
(
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [GPB_ADDR_W-1:0] PADDR,
  input wire logic [GPB_DATA_W-1:0] PWDATA,
  input wire logic [3:0]            PSTRB,
  input wire logic [GPB_DATA_W-1:0] PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire logic [GPB_PINS-1:0]   GPIO_A_IN,
  input wire logic [GPB_PINS-1:0]   GPIO_A_OUT,
  input wire logic [GPB_PINS-1:0]   GPIO_A_OE,
  input wire logic [GPB_PINS-1:0]   GPIO_C_OE,
  input wire logic [GPB_PINS-1:0]   ALT_A_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Bus phase qualifiers; write data kept one cycle for the pin checks
  wire setup = PSEL && !PENABLE;
  wire wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB == 4'hF;
  wire rd_a = setup && !PWRITE && PADDR == GPB_OFF_BANK_A;
  logic [31:0] wd;
  always_ff @(posedge CLK) wd <= PWDATA;
  // Zero wait states, so ready marks exactly the access cycle
  AST_READY_ACCESS: assert property (PREADY == $past(setup)) else $error("ready off");
  AST_UNMAPPED_ERR: assert property (setup && PADDR > GPB_OFF_BANK_C |=>
    PSLVERR && PRDATA == GPB_RD_UNMAPPED) else $error("unmapped answer");
  AST_A_NO_SPF: assert property (rd_a |=> PRDATA[15:8] == 8'h00) else $error("a spf");
  AST_A_PIN_READ: assert property (rd_a |=> PRDATA[7:0] == $past(GPIO_A_IN))
    else $error("a pins");
  AST_A_OE_DIR: assert property (wr && PADDR == GPB_OFF_BANK_A |=>
    ((GPIO_A_OE ^ wd[23:16]) & ~wd[31:24]) == 8'h00) else $error("a oe");
  AST_A_OUT_DATA: assert property (wr && PADDR == GPB_OFF_BANK_A |=>
    ((GPIO_A_OUT ^ wd[7:0]) & wd[23:16] & ~wd[31:24]) == 8'h00) else $error("a out");
  AST_C_OE_DIR: assert property (wr && PADDR == GPB_OFF_BANK_C |=>
    ((GPIO_C_OE ^ wd[23:16]) & ~(wd[31:24] | wd[15:8])) == 8'h00) else $error("c oe");
  AST_A_ALT_OE: assert property (wr && PADDR == GPB_OFF_BANK_A &&
    PWDATA[31:24] == 8'hFF |=> GPIO_A_OE == $past(ALT_A_OE)) else $error("a alt");
endmodule : gpb_pair_asserts

bind gpb_gpio_bank_pair gpb_pair_asserts u_chk (.*);

// [gpb_pin_bank.sv]
// Constants package for the two-bank GPIO block, and one eight-pin bank.
// Assumes the bank's write strobe and merged write word come from the
// register slave, and that the pin levels are already synchronous to clk.

package gpb_pkg;
  localparam int          GPB_PINS        = 8;        // Pins per bank
  localparam int          GPB_BANKS       = 2;        // Bank a and bank c
  localparam int          GPB_ADDR_W      = 12;
  localparam int          GPB_DATA_W      = 32;
  // Register byte addresses
  localparam logic [11:0] GPB_OFF_BANK_A  = 12'h000;
  localparam logic [11:0] GPB_OFF_BANK_C  = 12'h004;
  // Field positions: one byte lane per field, one bit per pin
  localparam int          GPB_FLD_DATA    = 0;
  localparam int          GPB_FLD_SPF     = 8;
  localparam int          GPB_FLD_DIR     = 16;
  localparam int          GPB_FLD_FSEL    = 24;
  // Reset values: every pin a plain input
  localparam logic [7:0]  GPB_RST_FSEL    = 8'h00;
  localparam logic [7:0]  GPB_RST_DIR     = 8'h00;
  localparam logic [7:0]  GPB_RST_SPF     = 8'h00;
  localparam logic [7:0]  GPB_RST_DATA    = 8'h00;
  localparam logic [31:0] GPB_RD_UNMAPPED = 32'h0000_0000;
endpackage : gpb_pkg

`timescale 1ns/10ps

module gpb_pin_bank
  import gpb_pkg::*;
#(
  parameter bit HAS_SPF = 1'b1
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wr_en,
  input  wire logic [GPB_DATA_W-1:0] wr_word,
  input  wire logic [GPB_PINS-1:0]   alt_out,
  input  wire logic [GPB_PINS-1:0]   alt_oe,
  input  wire logic [GPB_PINS-1:0]   spf_out,
  input  wire logic [GPB_PINS-1:0]   spf_oe,
  output logic      [GPB_DATA_W-1:0] cfg_word,
  output logic      [GPB_PINS-1:0]   pin_out,
  output logic      [GPB_PINS-1:0]   pin_oe
);

  logic [GPB_PINS-1:0] fsel;
  logic [GPB_PINS-1:0] dir;
  logic [GPB_PINS-1:0] spf;
  logic [GPB_PINS-1:0] dout;
  logic [GPB_PINS-1:0] next_fsel;
  logic [GPB_PINS-1:0] next_dir;
  logic [GPB_PINS-1:0] next_spf;
  logic [GPB_PINS-1:0] next_dout;
  logic [GPB_PINS-1:0] next_pin_out;
  logic [GPB_PINS-1:0] next_pin_oe;

  // Configuration fields load as one word from the slave
  always_comb begin
    next_fsel = fsel;
    next_dir  = dir;
    next_spf  = spf;
    next_dout = dout;
    if (wr_en) begin
      next_fsel = wr_word[GPB_FLD_FSEL +: GPB_PINS];
      next_dir  = wr_word[GPB_FLD_DIR  +: GPB_PINS];
      next_dout = wr_word[GPB_FLD_DATA +: GPB_PINS];
      // No special function bit exists in bank a: stays zero
      next_spf  = HAS_SPF ? wr_word[GPB_FLD_SPF +: GPB_PINS] : GPB_RST_SPF;
    end
  end

  // Per-pin output mux, from the next values so pins move with the write
  for (genvar i = 0; i < GPB_PINS; i++) begin : g_pin
    always_comb begin
      if (next_fsel[i]) begin
        next_pin_out[i] = alt_out[i];
        next_pin_oe[i]  = alt_oe[i];
      end else if (next_spf[i]) begin
        next_pin_out[i] = spf_out[i];
        next_pin_oe[i]  = spf_oe[i];
      end else begin
        next_pin_out[i] = next_dout[i];
        next_pin_oe[i]  = next_dir[i];
      end
    end
  end

  // Registers only; outputs leave straight from these
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fsel    <= GPB_RST_FSEL;
      dir     <= GPB_RST_DIR;
      spf     <= GPB_RST_SPF;
      dout    <= GPB_RST_DATA;
      pin_out <= GPB_RST_DATA;
      pin_oe  <= GPB_RST_DIR;
    end else begin
      fsel    <= next_fsel;
      dir     <= next_dir;
      spf     <= next_spf;
      dout    <= next_dout;
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  // Four fields of eight pins each fill the word
  assign cfg_word = {fsel, dir, spf, dout};

endmodule : gpb_pin_bank

// [gpb_pin_partner.sv]
// Board side of one eight-pin bank: switches on every released pin.
// Assumes the block wins on any pin whose enable it holds high.
`timescale 1ns/10ps
module gpb_pin_partner
  import gpb_pkg::*;
(
  input  wire logic [GPB_PINS-1:0] pin_out,
  input  wire logic [GPB_PINS-1:0] pin_oe,
  input  wire logic [GPB_PINS-1:0] sw_lvl,
  output logic      [GPB_PINS-1:0] pin_lvl
);
  // Driven pins read back the block's level; released ones the switch
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & sw_lvl);
endmodule : gpb_pin_partner

// [gpio_bank_pair_tb.sv]
// Self-checking bench for the GPIO bank pair over APB.
// Assumes one-cycle ready; the board model supplies released pin levels.
`timescale 1ns/10ps
module gpio_bank_pair_tb
  import gpb_pkg::*;
;
  logic        CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic        PREADY, PSLVERR, err;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
  logic [3:0]  PSTRB = 4'hF;
  logic [7:0]  a_in, a_out, a_oe, c_in, c_out, c_oe, sw_a = 8'h5A, sw_c = 8'hC3;
  logic [7:0]  alt_o = 8'h14, alt_e = 8'h3C, spf_o = 8'h05, spf_e = 8'h0F;
  int          fails = 0, compares = 0;
  always #2 CLK = ~CLK;
  gpb_gpio_bank_pair i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .GPIO_A_IN(a_in), .GPIO_A_OUT(a_out),
    .GPIO_A_OE(a_oe), .GPIO_C_IN(c_in), .GPIO_C_OUT(c_out), .GPIO_C_OE(c_oe),
    .ALT_A_OUT(alt_o), .ALT_A_OE(alt_e), .ALT_C_OUT(alt_o), .ALT_C_OE(alt_e),
    .SPF_C_OUT(spf_o), .SPF_C_OE(spf_e));
  gpb_pin_partner p_a (.pin_out(a_out), .pin_oe(a_oe), .sw_lvl(sw_a), .pin_lvl(a_in));
  gpb_pin_partner p_c (.pin_out(c_out), .pin_oe(c_oe), .sw_lvl(sw_c), .pin_lvl(c_in));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One APB transfer, called just after a rising edge; request held until
  // ready is seen at a rising edge, then one idle edge so pins have settled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CLK);
    end
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  // Out of reset every pin is a released input
  task automatic t_input();
    chk("a_oe", 32'h0, a_oe);
    apb(1'b0, GPB_OFF_BANK_C, 32'h0);
    chk("c_read", {24'h0, sw_c}, rd);
  endtask : t_input
  // Plain outputs drive the data lane and read back through the pins
  task automatic t_output();
    apb(1'b1, GPB_OFF_BANK_A, 32'h00FF_00A5);
    chk("a_oe", 32'hFF, a_oe);
    chk("a_out", 32'hA5, a_out);
    apb(1'b0, GPB_OFF_BANK_A, 32'h0);
    chk("a_read", 32'h00FF_00A5, rd);
  endtask : t_output
  // Special lane is absent on bank a and selects its source on bank c
  task automatic t_special();
    apb(1'b1, GPB_OFF_BANK_A, 32'h0000_FF00);
    apb(1'b0, GPB_OFF_BANK_A, 32'h0);
    chk("a_spf_read", {24'h0, sw_a}, rd);
    apb(1'b1, GPB_OFF_BANK_C, 32'h0000_FF00);
    chk("c_oe", {24'h0, spf_e}, c_oe);
    chk("c_out", {24'h0, spf_o}, c_out);
    apb(1'b0, GPB_OFF_BANK_C, 32'h0);
    chk("c_read", {16'h0, 8'hFF, (spf_e & spf_o) | (~spf_e & sw_c)}, rd);
  endtask : t_special
  // Function select hands bank a to the alternate source
  task automatic t_alt();
    apb(1'b1, GPB_OFF_BANK_A, 32'hFF00_0000);
    chk("a_alt_oe", {24'h0, alt_e}, a_oe);
    chk("a_alt_out", {24'h0, alt_o}, a_out);
  endtask : t_alt
  // Beyond bank c the slave errors and leaves the pins alone
  task automatic t_unmapped();
    apb(1'b0, 12'h008, 32'h0);
    chk("unm_err", 32'h1, err);
    chk("unm_data", GPB_RD_UNMAPPED, rd);
    apb(1'b1, 12'h00C, 32'h00FF_0000);
    chk("unm_oe", {24'h0, alt_e}, a_oe);
  endtask : t_unmapped
  // Read-modify-write turns pin 7 of bank c into a low output, others keep roles;
  // the data lane reads pin levels, so the write-back copies them into the latch
  task automatic t_rmw();
    logic [31:0] w;
    logic [7:0]  e_oe;
    logic [7:0]  e_out;
    logic [7:0]  e_pin;
    e_oe  = (spf_e & 8'h7F) | 8'h80;
    e_out = spf_o & 8'h7F;
    e_pin = (e_oe & e_out) | (~e_oe & sw_c);
    apb(1'b0, GPB_OFF_BANK_C, 32'h0);
    w = rd;
    w[GPB_FLD_DIR + 7]  = 1'b1;
    w[GPB_FLD_SPF + 7]  = 1'b0;
    w[GPB_FLD_DATA + 7] = 1'b0;
    apb(1'b1, GPB_OFF_BANK_C, w);
    chk("c_rmw_oe", {24'h0, e_oe}, c_oe);
    chk("c_rmw_out", {24'h0, e_out}, c_out);
    apb(1'b0, GPB_OFF_BANK_C, 32'h0);
    chk("c_rmw_read", {16'h0080, 8'h7F, e_pin}, rd);
    // Only the function select lane strobed: direction and data lanes ignored
    PSTRB <= 4'h8;
    apb(1'b1, GPB_OFF_BANK_A, 32'h00FF_FFFF);
    PSTRB <= 4'hF;
    chk("a_strb_oe", 32'h0, a_oe);
    chk("a_strb_out", 32'h0, a_out);
  endtask : t_rmw
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Hang guard, far beyond the fourteen transfers above
  initial begin
    #20000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    t_input();
    t_output();
    t_special();
    t_alt();
    t_unmapped();
    t_rmw();
    complete_run();
  end
endmodule : gpio_bank_pair_tb
